// ==== rtl/lp_pkg.sv ====
// Shared constants and types for the low-power stop and wait controller.
`default_nettype none

package lp_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets on the register bus.
    localparam logic [3:0] OFS_MODE = 4'h0;
    localparam logic [3:0] OFS_TIMER_EN = 4'h4;
    localparam logic [3:0] OFS_WDOG = 4'h8;
    localparam logic [3:0] OFS_IRQ_STAT = 4'hC;

    // The mask register and the last-vector register sit above the first four.
    localparam logic [4:0] OFS_IRQ_MASK = 5'h10;
    localparam logic [4:0] OFS_VECTOR = 5'h14;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions.
    localparam int MODE_STOP_BIT = 0;
    localparam int MODE_WAIT_BIT = 1;
    localparam int MODE_IMASK_BIT = 2;
    localparam int WDOG_RESTART_BIT = 0;
    localparam int EVT_EXT_WAKE = 0;
    localparam int EVT_TIMER_WAKE = 1;
    localparam int EVT_WDOG = 2;
    localparam int EVT_COUNT = 3;

    ////////////////////////////////////////////////////////////////////////////
    // Vectors and reset values.
    localparam logic [15:0] EXT_VEC = 16'h1FFA;
    localparam logic [15:0] RESET_VEC = 16'h1FFE;
    localparam logic [15:0] TIMER_VEC_DEFAULT = 16'h1FF8;
    localparam logic [2:0] EVT_MASK_RESET = 3'h0;
    localparam logic IMASK_RESET = 1'b1;

    // Watchdog: eighteen ripple stages give its timeout in clock cycles.
    localparam int WDOG_STAGES = 18;
    localparam int WDOG_LIMIT_DEFAULT = 2 ** WDOG_STAGES;

    ////////////////////////////////////////////////////////////////////////////
    // Types.
    typedef enum logic [1:0] {
        MODE_RUN = 2'b00,
        MODE_WAIT = 2'b01,
        MODE_STOP = 2'b10
    } mode_t;

    typedef struct packed {
        logic capture_int_enable;
        logic compare_int_enable;
        logic overflow_int_enable;
    } timer_en_t;

    localparam timer_en_t TIMER_EN_RESET = '{1'b0, 1'b0, 1'b0};

endpackage

`default_nettype wire

// ==== rtl/sticky_flags.sv ====
// Sticky event flags, set by hardware and cleared by writing ones.
`default_nettype none

module sticky_flags #(
    parameter int WIDTH = 3
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst,
    // Set and clear strobes, one bit per flag.
    input wire logic [WIDTH-1:0] set,
    input wire logic [WIDTH-1:0] clr,
    // Held flags.
    output logic [WIDTH-1:0] flags
);

    // A set arriving with its clear wins, so no event is ever lost.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            flags <= '0;
        end else begin
            flags <= (flags & ~clr) | set;
        end
    end

endmodule

`default_nettype wire

// ==== rtl/lp_control.sv ====
// Stop and wait low-power mode controller with watchdog and register slave.
//
// What this block does
// - Stop mode halts the oscillator, timer counting and watchdog counting.
// - Entering stop clears capture, compare and overflow interrupt enables.
// - Entering stop clears the timer prescaler.
// - Entering stop clears the interrupt mask so external interrupts get in.
// - Stop changes nothing else: other registers, memory and lines keep state.
// - Only an external interrupt or a reset ends stop mode.
// - External wake from stop loads the vector at 1FFA and 1FFB.
// - Reset loads the vector at 1FFE and 1FFF.
// - In wait the CPU halts while the timer and its clocks run.
// - An enabled timer interrupt ends wait and starts servicing.
// - The watchdog keeps counting in wait and may force a reset.
// - Entering wait clears the interrupt mask.
// - Wait changes nothing but the interrupt mask.
// - Any reset clears the stop and wait latches.
// - Timer interrupt needs flag and enable, taken only with mask clear.
// - External interrupt is a falling pin, taken only with mask clear.
//
// Our own choices: the address map and the Avalon-MM register port.
`default_nettype none

module lp_control #(
    parameter int WDOG_LIMIT = lp_pkg::WDOG_LIMIT_DEFAULT,
    parameter logic [15:0] TIMER_VEC = lp_pkg::TIMER_VEC_DEFAULT
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst,
    // Avalon-MM slave.
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Core side: instruction strobes and interrupt sources.
    input wire logic stop_exec,
    input wire logic wait_exec,
    input wire logic irq_n,
    input wire logic [2:0] timer_flags,
    // Power and clock control.
    output logic osc_run,
    output logic timer_run,
    output logic cpu_halt,
    output logic prescaler_clear,
    // Interrupt servicing and vector fetch.
    output logic int_mask,
    output logic int_service,
    output logic vector_load,
    output logic [15:0] vector_addr,
    output logic wdog_reset,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////
    // State.
    lp_pkg::mode_t mode;
    lp_pkg::mode_t next_mode;
    lp_pkg::timer_en_t timer_en;
    // One stage more than the ripple chain, so the full count fits.
    localparam int WDOG_STAGES_W = lp_pkg::WDOG_STAGES + 1;
    logic [WDOG_STAGES_W-1:0] wdog_cnt;
    logic irq_n_prev;
    logic ext_pend;
    logic [2:0] evt_mask;
    logic [2:0] evt_stat;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode. A request waits one cycle, then is accepted with waitrequest low.
    wire bus_req = avs_read | avs_write;
    wire bus_acc = bus_req & ~avs_waitrequest;
    wire wr_acc = avs_write & ~avs_waitrequest;
    wire wr_mode = wr_acc & (avs_address == {1'b0, lp_pkg::OFS_MODE});
    wire wr_ten = wr_acc & (avs_address == {1'b0, lp_pkg::OFS_TIMER_EN});
    wire wr_wdog = wr_acc & (avs_address == {1'b0, lp_pkg::OFS_WDOG});
    wire wr_stat = wr_acc & (avs_address == {1'b0, lp_pkg::OFS_IRQ_STAT});
    wire wr_mask = wr_acc & (avs_address == lp_pkg::OFS_IRQ_MASK);
    wire wdog_restart = wr_wdog & ~avs_writedata[lp_pkg::WDOG_RESTART_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt qualification and mode change decisions.
    wire timer_req = |(timer_flags & timer_en);
    wire ext_take = ext_pend & ~int_mask;
    wire timer_take = timer_req & ~int_mask & (mode != lp_pkg::MODE_STOP);
    wire take = ext_take | timer_take;
    // The expiry is gated by counting: a count frozen at its last value in stop
    // must not act as a wake source, so it is seen only once the core runs again.
    wire wdog_counting = (mode != lp_pkg::MODE_STOP);
    wire wdog_timeout = wdog_counting & (wdog_cnt == WDOG_STAGES_W'(WDOG_LIMIT - 1));
    wire stop_entry = stop_exec & (mode == lp_pkg::MODE_RUN) & ~take & ~wdog_timeout;
    wire wait_entry = wait_exec & (mode == lp_pkg::MODE_RUN) & ~take & ~wdog_timeout & ~stop_exec;
    wire ext_fall = irq_n_prev & ~irq_n;

    // Mode selection; a taken interrupt always returns the core to running.
    assign next_mode = wdog_timeout ? lp_pkg::MODE_RUN :
                       take ? lp_pkg::MODE_RUN :
                       stop_entry ? lp_pkg::MODE_STOP :
                       wait_entry ? lp_pkg::MODE_WAIT : mode;

    ////////////////////////////////////////////////////////////////////////////
    // Mode latch and the control outputs registered from the same next value.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mode <= lp_pkg::MODE_RUN;
            osc_run <= 1'b1;
            timer_run <= 1'b1;
            cpu_halt <= 1'b0;
        end else begin
            mode <= next_mode;
            osc_run <= (next_mode != lp_pkg::MODE_STOP);
            timer_run <= (next_mode != lp_pkg::MODE_STOP);
            cpu_halt <= (next_mode != lp_pkg::MODE_RUN);
        end
    end

    // Timer enables: software owns them, stop and watchdog reset clear them.
    // Wait entry leaves them alone; a stop entry outranks a write in the same cycle.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            timer_en <= lp_pkg::TIMER_EN_RESET;
        end else if (stop_entry | wdog_timeout) begin
            timer_en <= lp_pkg::TIMER_EN_RESET;
        end else if (wr_ten) begin
            timer_en <= avs_writedata[2:0];
        end
    end

    // Interrupt mask bit of the condition code register.
    always_ff @(posedge clk_sys) begin
        if (rst | wdog_timeout) begin
            int_mask <= lp_pkg::IMASK_RESET;
        end else if (take) begin
            int_mask <= 1'b1;
        end else if (stop_entry) begin
            int_mask <= 1'b0;
        end else if (wait_entry) begin
            int_mask <= 1'b0;
        end else if (wr_mode) begin
            int_mask <= avs_writedata[lp_pkg::MODE_IMASK_BIT];
        end
    end

    // External request latch on a falling pin; a new edge beats the clear.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_n_prev <= 1'b1;
            ext_pend <= 1'b0;
        end else begin
            irq_n_prev <= irq_n;
            ext_pend <= ext_fall | (ext_pend & ~ext_take);
        end
    end

    // Watchdog counter. It freezes with the oscillator in stop and runs in wait.
    always_ff @(posedge clk_sys) begin
        if (rst | wdog_restart | wdog_timeout) begin
            wdog_cnt <= '0;
        end else if (wdog_counting) begin
            wdog_cnt <= wdog_cnt + 1'b1;
        end
    end

    // Strobes and vectors. The reset vector is presented during and just after reset.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            vector_load <= 1'b1;
            vector_addr <= lp_pkg::RESET_VEC;
            int_service <= 1'b0;
            prescaler_clear <= 1'b0;
            wdog_reset <= 1'b0;
        end else begin
            vector_load <= take | wdog_timeout;
            if (wdog_timeout) begin
                vector_addr <= lp_pkg::RESET_VEC;
            end else if (ext_take) begin
                vector_addr <= lp_pkg::EXT_VEC;
            end else if (timer_take) begin
                vector_addr <= TIMER_VEC;
            end
            int_service <= take & ~wdog_timeout;
            prescaler_clear <= stop_entry;
            wdog_reset <= wdog_timeout;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Event flags for the system interrupt line.
    wire [2:0] evt_set = {wdog_timeout,
                          timer_take & ~ext_take & (mode == lp_pkg::MODE_WAIT),
                          ext_take & (mode == lp_pkg::MODE_STOP)};
    wire [2:0] evt_clr = wr_stat ? avs_writedata[2:0] : 3'h0;

    sticky_flags #(.WIDTH(lp_pkg::EVT_COUNT)) u_events (
        .clk_sys(clk_sys),
        .rst(rst),
        .set(evt_set),
        .clr(evt_clr),
        .flags(evt_stat)
    );

    // Mask register and the level interrupt, registered to keep the output clean.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            evt_mask <= lp_pkg::EVT_MASK_RESET;
            irq <= 1'b0;
        end else begin
            if (wr_mask) begin
                evt_mask <= avs_writedata[2:0];
            end
            irq <= |(evt_stat & evt_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux; unmapped addresses read as zero and ignore writes.
    wire [31:0] rd_mode = {29'h0, int_mask, mode == lp_pkg::MODE_WAIT,
                           mode == lp_pkg::MODE_STOP};
    wire [31:0] rd_mux =
        (avs_address == {1'b0, lp_pkg::OFS_MODE}) ? rd_mode :
        (avs_address == {1'b0, lp_pkg::OFS_TIMER_EN}) ? {29'h0, timer_en} :
        (avs_address == {1'b0, lp_pkg::OFS_WDOG}) ? {13'h0, wdog_cnt} :
        (avs_address == {1'b0, lp_pkg::OFS_IRQ_STAT}) ? {29'h0, evt_stat} :
        (avs_address == lp_pkg::OFS_IRQ_MASK) ? {29'h0, evt_mask} :
        (avs_address == lp_pkg::OFS_VECTOR) ? {16'h0, vector_addr} : 32'h0;

    // Waitrequest drops for one cycle per request; read data is captured then.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0;
        end else begin
            avs_waitrequest <= ~(bus_req & avs_waitrequest);
            if (avs_read & avs_waitrequest) begin
                avs_readdata <= rd_mux;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks. They run on the system clock and rest while reset is high; reset
    // rises and falls on clock edges, so no attempt straddles a release.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // The first stop cycle still shows the increment made while running, and a
    // restart written in stop clears the count, so only a settled count is held.
    stop_halts_clock_a: assert property (
        (mode == lp_pkg::MODE_STOP) |-> !osc_run && !timer_run &&
            ($past(mode) != lp_pkg::MODE_STOP || $past(wdog_restart) || $stable(wdog_cnt)))
        else $error("Stop mode left a clock or the watchdog running.");
    stop_clears_en_a: assert property (
        stop_entry |=> timer_en == lp_pkg::TIMER_EN_RESET)
        else $error("Timer enables not cleared on stop entry.");
    prescaler_pulse_a: assert property (
        stop_entry |=> prescaler_clear ##1 !prescaler_clear)
        else $error("Prescaler clear not a single pulse on stop entry.");
    stop_mask_clear_a: assert property (stop_entry |=> !int_mask)
        else $error("Interrupt mask not cleared on stop entry.");
    stop_keeps_en_a: assert property (
        (mode == lp_pkg::MODE_STOP && !wr_ten && !wdog_timeout) |=> $stable(timer_en))
        else $error("Timer enables changed while stopped.");
    stop_wake_only_a: assert property (
        (mode == lp_pkg::MODE_STOP && !ext_pend) |=> mode == lp_pkg::MODE_STOP)
        else $error("Stop mode left without external interrupt.");
    ext_vector_a: assert property (
        (mode == lp_pkg::MODE_STOP && ext_take) |=>
            vector_load && vector_addr == lp_pkg::EXT_VEC && mode == lp_pkg::MODE_RUN)
        else $error("External wake did not load its vector.");
    // The reset vector must stand on the first edge after release, before any fetch.
    reset_vector_a: assert property (
        $past(rst) |-> vector_load && vector_addr == lp_pkg::RESET_VEC)
        else $error("Reset vector not presented after reset.");
    wait_timer_runs_a: assert property (
        (mode == lp_pkg::MODE_WAIT) |-> cpu_halt && timer_run && osc_run)
        else $error("Wait mode stopped the timer or ran the core.");
    wait_timer_wake_a: assert property (
        (mode == lp_pkg::MODE_WAIT && timer_take && !wdog_timeout) |=>
            int_service && mode == lp_pkg::MODE_RUN ##1 !int_service)
        else $error("Timer interrupt did not end wait mode.");
    wait_wdog_counts_a: assert property (
        (mode == lp_pkg::MODE_WAIT && !wdog_restart && !wdog_timeout) |=>
            wdog_cnt == $past(wdog_cnt) + 1'b1)
        else $error("Watchdog stopped counting in wait.");
    wait_mask_clear_a: assert property (wait_entry |=> !int_mask && cpu_halt)
        else $error("Interrupt mask not cleared on wait entry.");
    mask_blocks_a: assert property (int_mask |-> !take)
        else $error("Interrupt taken while masked.");
    // A watchdog expiry in the same cycle outranks the pin and shows the reset vector.
    wait_ext_wake_a: assert property (
        (mode == lp_pkg::MODE_WAIT && ext_take && !wdog_timeout) |=>
            mode == lp_pkg::MODE_RUN && vector_addr == lp_pkg::EXT_VEC)
        else $error("External interrupt did not end wait mode.");

    // Covers mark the main scenarios: both wakes from wait, the wake from stop,
    // a watchdog expiry and a mask register write.
    stop_wake_c: cover property (mode == lp_pkg::MODE_STOP ##1 mode == lp_pkg::MODE_RUN);
    wait_wake_c: cover property (mode == lp_pkg::MODE_WAIT && timer_take);
    ext_wait_wake_c: cover property (mode == lp_pkg::MODE_WAIT && ext_take);
    wdog_fire_c: cover property (wdog_reset);
    bus_write_c: cover property (wr_mask);

endmodule

`default_nettype wire

// ==== verification/ext_irq_model.sv ====
// Behavioural external interrupt source on the active-low interrupt pin.
`default_nettype none

module ext_irq_model (
    // Clock.
    input wire logic clk_sys,
    // Request from the bench to pull the pin low.
    input wire logic fire,
    // Interrupt pin, pulled up whenever the source lets go.
    output var logic irq_n
);
    timeunit 1ns;
    timeprecision 1ps;

    int hold = 0;

    // The pin idles high through its pull-up, so a released pin never floats.
    initial irq_n = 1'h1;

    ////////////////////////////////////////////////////////////////////////////
    // A request holds the pin low for a few cycles; the device latches the falling edge.
    always @(posedge clk_sys) begin
        hold <= fire ? 3 : (hold > 0 ? hold - 1 : 0);
        irq_n <= !(fire || hold > 1);
    end
endmodule

`default_nettype wire

// ==== verification/low_power_stop_wait_control_bench.sv ====
// Self-checking bench for the stop and wait low-power controller.
`default_nettype none

module low_power_stop_wait_control_bench;
    timeunit 1ns;
    timeprecision 1ps;

    // A short watchdog keeps the timeout scenario quick.
    localparam int LIMIT = 1024;
    localparam logic [15:0] TVEC = 16'h1F00;
    localparam logic [4:0] A_MODE = {1'h0, lp_pkg::OFS_MODE};
    localparam logic [4:0] A_EN = {1'h0, lp_pkg::OFS_TIMER_EN};
    localparam logic [4:0] A_WD = {1'h0, lp_pkg::OFS_WDOG};
    localparam logic [4:0] A_ST = {1'h0, lp_pkg::OFS_IRQ_STAT};

    logic clk_sys = 1'h0;
    logic rst = 1'h1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'h0;
    logic avs_write = 1'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic stop_exec = 1'h0;
    logic wait_exec = 1'h0;
    logic fire = 1'h0;
    logic irq_n;
    logic [2:0] timer_flags = 3'h0;
    logic osc_run, timer_run, cpu_halt, prescaler_clear, int_mask, int_service;
    logic vector_load, wdog_reset, irq;
    logic [15:0] vector_addr;
    int err_count = 0;
    int checks_done = 0;
    int svc_cnt = 0;
    int pclr_cnt = 0;
    int wd_cnt = 0;
    int s;
    integer seed = 32'h0491;
    logic [31:0] rd, w0;
    logic [2:0] en;

    always #5 clk_sys = ~clk_sys;

    lp_control #(.WDOG_LIMIT(LIMIT), .TIMER_VEC(TVEC)) u_dut (.clk_sys(clk_sys), .rst(rst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .stop_exec(stop_exec), .wait_exec(wait_exec),
        .irq_n(irq_n), .timer_flags(timer_flags), .osc_run(osc_run), .timer_run(timer_run),
        .cpu_halt(cpu_halt), .prescaler_clear(prescaler_clear), .int_mask(int_mask),
        .int_service(int_service), .vector_load(vector_load), .vector_addr(vector_addr),
        .wdog_reset(wdog_reset), .irq(irq));

    ext_irq_model u_irq (.clk_sys(clk_sys), .fire(fire), .irq_n(irq_n));

    ////////////////////////////////////////////////////////////////////////////
    // Pulses are counted so a scenario can wait on them without racing the edge.
    always @(posedge clk_sys) begin
        if (int_service === 1'h1) svc_cnt <= svc_cnt + 1;
        if (prescaler_clear === 1'h1) pclr_cnt <= pclr_cnt + 1;
        if (wdog_reset === 1'h1) wd_cnt <= wd_cnt + 1;
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One Avalon transfer; the request is held until waitrequest is sampled low.
    // A slave that never answers is left to the watchdog process below.
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clk_sys);
        end while (avs_waitrequest !== 1'h0);
        rd = avs_readdata;
        avs_write <= 1'h0;
        avs_read <= 1'h0;
    endtask

    task automatic rchk(input string what, input logic [4:0] a, input logic [31:0] exp);
        bus(1'h0, a, 32'h0);
        chk(what, rd, exp);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // One-cycle instruction strobe: stop when sel is high, wait otherwise.
    task automatic strobe(input logic sel);
        @(posedge clk_sys);
        stop_exec <= sel;
        wait_exec <= !sel;
        @(posedge clk_sys);
        stop_exec <= 1'h0;
        wait_exec <= 1'h0;
        tick(1);
    endtask

    task automatic pin_irq;
        @(posedge clk_sys);
        fire <= 1'h1;
        @(posedge clk_sys);
        fire <= 1'h0;
    endtask

    // Bounded wait for a pulse counter to reach its target.
    task automatic wait_cnt(ref int cnt, input int target, input string what);
        for (int i = 0; i < 3 * LIMIT && cnt < target; i++) @(posedge clk_sys);
        tick(1);
        chk(what, cnt, target);
    endtask

    task automatic pulse_rst;
        @(posedge clk_sys);
        rst <= 1'h1;
        @(posedge clk_sys);
        rst <= 1'h0;
        tick(1);
        chk("halt after reset", cpu_halt, 1'h0);
        chk("osc after reset", osc_run, 1'h1);
        chk("reset vector", vector_addr, 16'h1FFE);
    endtask

    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // A hang is cut short well beyond the expected run length.
    initial begin
        repeat (30000) @(posedge clk_sys);
        err_count++;
        wrap_up();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        tick(3);
        chk("reset vector", vector_addr, 16'h1FFE);
        chk("halt in reset", cpu_halt, 1'h0);
        chk("vector load in reset", vector_load, 1'h1);
        @(posedge clk_sys);
        rst <= 1'h0;
        rchk("mode reset", A_MODE, 32'h4);
        rchk("enable reset", A_EN, 32'h0);
        rchk("unmapped read", 5'h1C, 32'h0);
        bus(1'h1, 5'h1C, 32'hFFFFFFFF);
        // Masked timer request is held off until software clears the mask.
        en = 3'($random(seed)) | 3'h1;
        bus(1'h1, A_WD, 32'h0);
        bus(1'h1, A_EN, {29'h0, en});
        timer_flags <= en;
        tick(6);
        chk("masked timer", svc_cnt, 0);
        bus(1'h1, A_MODE, 32'h0);
        wait_cnt(svc_cnt, 1, "timer taken");
        chk("timer vector", vector_addr, TVEC);
        chk("mask set on take", int_mask, 1'h1);
        @(posedge clk_sys);
        timer_flags <= 3'h0;
        // Stop: clocks halt, enables and prescaler clear, only the pin wakes.
        bus(1'h1, A_WD, 32'h0);
        bus(1'h1, 5'h10, 32'h6);
        strobe(1'h1);
        tick(1);
        chk("osc in stop", osc_run, 1'h0);
        chk("timer in stop", timer_run, 1'h0);
        chk("halt in stop", cpu_halt, 1'h1);
        chk("mask in stop", int_mask, 1'h0);
        chk("prescaler pulse", pclr_cnt, 1);
        rchk("enables in stop", A_EN, 32'h0);
        rchk("mask reg kept", 5'h10, 32'h6);
        bus(1'h0, A_WD, 32'h0);
        w0 = rd;
        timer_flags <= 3'h7;
        tick(20);
        rchk("wdog frozen", A_WD, w0);
        chk("timer no wake", cpu_halt, 1'h1);
        timer_flags <= 3'h0;
        pin_irq();
        wait_cnt(svc_cnt, 2, "ext wake");
        chk("ext vector", vector_addr, 16'h1FFA);
        chk("osc after wake", osc_run, 1'h1);
        rchk("ext wake status", A_ST, 32'h1);
        // Level interrupt follows status and mask, cleared by writing one.
        bus(1'h1, 5'h10, 32'h1);
        tick(2);
        chk("irq unmasked", irq, 1'h1);
        bus(1'h1, 5'h10, 32'h0);
        tick(2);
        chk("irq masked", irq, 1'h0);
        bus(1'h1, 5'h10, 32'h7);
        bus(1'h1, A_ST, 32'h1);
        tick(2);
        chk("irq cleared", irq, 1'h0);
        rchk("status cleared", A_ST, 32'h0);
        // Wait with each timer enable in turn; unenabled flags must not wake.
        for (int i = 0; i < 3; i++) begin
            en = 3'h1 << i;
            bus(1'h1, A_WD, 32'h0);
            bus(1'h1, A_EN, {29'h0, en});
            strobe(1'h0);
            chk("halt in wait", cpu_halt, 1'h1);
            chk("timer runs in wait", timer_run, 1'h1);
            chk("mask in wait", int_mask, 1'h0);
            rchk("mode in wait", A_MODE, 32'h2);
            bus(1'h0, A_WD, 32'h0);
            w0 = rd;
            bus(1'h0, A_WD, 32'h0);
            chk("wdog counts", {31'h0, rd > w0}, 32'h1);
            timer_flags <= 3'($random(seed)) & ~en;
            tick(6);
            chk("no enable no wake", cpu_halt, 1'h1);
            s = svc_cnt;
            @(posedge clk_sys);
            timer_flags <= en;
            wait_cnt(svc_cnt, s + 1, "timer wake");
            chk("timer wake vector", vector_addr, TVEC);
            chk("halt after wake", cpu_halt, 1'h0);
            @(posedge clk_sys);
            timer_flags <= 3'h0;
            rchk("enables kept", A_EN, {29'h0, en});
            rchk("timer wake status", A_ST, 32'h2);
            bus(1'h1, A_ST, 32'h2);
        end
        // Wait ended by the pin, by reset, and stop ended by reset.
        bus(1'h1, A_WD, 32'h0);
        strobe(1'h0);
        s = svc_cnt;
        pin_irq();
        wait_cnt(svc_cnt, s + 1, "ext ends wait");
        chk("ext wait vector", vector_addr, 16'h1FFA);
        strobe(1'h0);
        pulse_rst();
        strobe(1'h1);
        pulse_rst();
        // Watchdog left alone in wait forces a reset.
        strobe(1'h0);
        wait_cnt(wd_cnt, 1, "wdog timeout");
        chk("wdog wakes", cpu_halt, 1'h0);
        chk("wdog vector", vector_addr, 16'h1FFE);
        rchk("wdog status", A_ST, 32'h4);
        wrap_up();
    end
endmodule

`default_nettype wire
